//--- core/hrsp_defines.vh
// Register offsets, field positions and reset values of the humidity result/status/peak block.
`ifndef HRSP_DEFINES_VH
`define HRSP_DEFINES_VH

// Register offsets.
`define HRSP_OFS_TEMP_LOW 8'h00
`define HRSP_OFS_TEMP_HIGH 8'h01
`define HRSP_OFS_HUMID_LOW 8'h02
`define HRSP_OFS_HUMID_HIGH 8'h03
`define HRSP_OFS_EVENT_STATUS 8'h04
`define HRSP_OFS_TEMP_PEAK 8'h05
`define HRSP_OFS_HUMID_PEAK 8'h06
`define HRSP_OFS_EVENT_ENABLE 8'h07

// Bit positions shared by the status and enable registers.
`define HRSP_BIT_CONV_DONE 7
`define HRSP_BIT_TEMP_HIGH 6
`define HRSP_BIT_TEMP_LOW 5
`define HRSP_BIT_HUMID_HIGH 4
`define HRSP_BIT_HUMID_LOW 3
`define HRSP_FLAG_LSB 3
`define HRSP_NUM_FLAGS 5

// Reset values.
`define HRSP_RST_HUMID_RESULT 16'h0000
`define HRSP_RST_TEMP_RESULT 16'h0000
`define HRSP_RST_EVENT_STATUS 8'h00
`define HRSP_RST_PEAK 8'h00
`define HRSP_RST_EVENT_ENABLE 8'h00

// Resolution select codes and the low bits each one drops from the 14-bit value.
`define HRSP_RES_14BIT 2'h0
`define HRSP_RES_11BIT 2'h1
`define HRSP_RES_9BIT 2'h2
`define HRSP_MASK_14BIT 14'h3FFF
`define HRSP_MASK_11BIT 14'h3FF8
`define HRSP_MASK_9BIT 14'h3FE0

// Default 7-bit bus address of the device; the value is arbitrary.
`define HRSP_DEV_ADDR 7'h2A

`endif

//--- core/hrsp_sync.v
// Three-stage input synchroniser with agreement filter and edge pulses.
`timescale 1ns/1ps
`default_nettype none

module hrsp_sync #(
  parameter WIDTH = 2
) (
  // Clock and reset.
  input wire clk_sys,
  input wire srst,
  // Asynchronous inputs.
  input wire [WIDTH-1:0] async_in,
  // Filtered level and its edges.
  output reg [WIDTH-1:0] level_q,
  output reg [WIDTH-1:0] rise_q,
  output reg [WIDTH-1:0] fall_q
);

  reg [WIDTH-1:0] stage1_q;
  reg [WIDTH-1:0] stage2_q;
  reg [WIDTH-1:0] stage3_q;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      // A change is taken only once the second and third stages agree.
      always @(posedge clk_sys) begin
        if (srst) begin
          stage1_q[i] <= 1'b1;
          stage2_q[i] <= 1'b1;
          stage3_q[i] <= 1'b1;
          level_q[i] <= 1'b1;
          rise_q[i] <= 1'b0;
          fall_q[i] <= 1'b0;
        end else begin
          stage1_q[i] <= async_in[i];
          stage2_q[i] <= stage1_q[i];
          stage3_q[i] <= stage2_q[i];
          if (stage2_q[i] == stage3_q[i]) begin
            level_q[i] <= stage3_q[i];
          end
          rise_q[i] <= (stage2_q[i] == stage3_q[i]) && stage3_q[i] && !level_q[i];
          fall_q[i] <= (stage2_q[i] == stage3_q[i]) && !stage3_q[i] && level_q[i];
        end
      end
    end
  endgenerate

endmodule // hrsp_sync

`default_nettype wire

//--- core/hrsp_regs.v
// Humidity result, event status, peak detector and event enable registers behind a serial bus slave.
//
// What this block does
// - Humidity word 16 bits, low two zero.
// - Conversion 14 bits, resolution from setting.
// - Humidity bits 15:8 read-only at 0x03.
// - Humidity percent equals word/65536 times 100.
// - Status byte at 0x04, five flags.
// - Data-ready sets when any conversion finishes.
// - Data-ready clears on status or result read.
// - Temperature-high flag sets; status read clears.
// - Temperature-low flag sets; status read clears.
// - Humidity high/low flags set; status read clears.
// - Alert setting steers flags and alert pin.
// - Temperature peak byte kept at 0x05.
// - Humidity peak byte at 0x06, resets zero.
// - Peaks clear at reset and soft reset.
// - Peaks track host-requested conversions, not auto mode.
// - Temperature peak: byte/256*165 minus 40.5.
// - Humidity peak: byte*100/256 percent.
// - Enable byte at 0x07, five source enables.
// - Enable bit gates its source's interrupt.
// - Temperature: word/65536*165 minus 40.5.
`timescale 1ns/1ps
`default_nettype none
`include "hrsp_defines.vh"

module hrsp_regs #(
  parameter [6:0] DEV_ADDR = `HRSP_DEV_ADDR
) (
  // Clock and reset.
  input wire clk_sys,
  input wire srst,
  // Serial bus pins, open drain.
  input wire scl_i,
  input wire sda_i,
  output reg sda_o,
  output reg sda_oe,
  // Conversion results from the measurement engine.
  input wire temp_done,
  input wire [15:0] temp_word,
  input wire humid_done,
  input wire [13:0] humid_value,
  input wire [1:0] humid_res_sel,
  input wire auto_mode,
  // Threshold comparator conditions.
  input wire temp_over_high_cond,
  input wire temp_under_low_cond,
  input wire humid_over_high_cond,
  input wire humid_under_low_cond,
  // Alert pin configuration and soft reset.
  input wire alert_enable,
  input wire alert_active_high,
  input wire alert_level_mode,
  input wire soft_reset,
  // Alert pin.
  output reg alert_pin
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ADDR = 3'h1;
  localparam [2:0] ST_ACK = 3'h2;
  localparam [2:0] ST_PTR = 3'h3;
  localparam [2:0] ST_WDATA = 3'h4;
  localparam [2:0] ST_TX = 3'h5;
  localparam [2:0] ST_RACK = 3'h6;

  localparam NF = `HRSP_NUM_FLAGS;

  // Synchronised bus pins.
  wire [1:0] pin_level;
  wire [1:0] pin_rise;
  wire [1:0] pin_fall;

  hrsp_sync #(
    .WIDTH(2)
  ) u_sync (
    .clk_sys(clk_sys),
    .srst(srst),
    .async_in({sda_i, scl_i}),
    .level_q(pin_level),
    .rise_q(pin_rise),
    .fall_q(pin_fall)
  );

  wire scl_rise = pin_rise[0];
  wire scl_fall = pin_fall[0];
  wire scl_high = pin_level[0];
  wire sda_in = pin_level[1];
  wire bus_start = pin_fall[1] && scl_high;
  wire bus_stop = pin_rise[1] && scl_high;

  // Register state.
  reg [15:0] temp_word_q;
  reg [15:0] humid_word_q;
  reg [NF-1:0] flag_q;
  reg [7:0] temp_peak_q;
  reg [7:0] humid_peak_q;
  reg [NF-1:0] enable_q;

  // Bus slave state.
  reg [2:0] state_q;
  reg [7:0] shift_q;
  reg [3:0] bit_cnt_q;
  reg byte_done_q;
  reg rw_q;
  reg ptr_valid_q;
  reg [7:0] ptr_q;
  reg [7:0] tx_q;
  reg nack_q;
  reg rd_evt_q;
  reg [7:0] rd_addr_q;
  reg wr_evt_q;
  reg [7:0] wr_addr_q;
  reg [7:0] wr_data_q;

  // Read view of one register; unmapped offsets read zero.
  function [7:0] rd_mux;
    input [7:0] addr;
    begin
      case (addr)
        `HRSP_OFS_TEMP_LOW: rd_mux = temp_word_q[7:0];
        `HRSP_OFS_TEMP_HIGH: rd_mux = temp_word_q[15:8];
        `HRSP_OFS_HUMID_LOW: rd_mux = humid_word_q[7:0];
        `HRSP_OFS_HUMID_HIGH: rd_mux = humid_word_q[15:8];
        `HRSP_OFS_EVENT_STATUS: rd_mux = {flag_q, 3'h0};
        `HRSP_OFS_TEMP_PEAK: rd_mux = temp_peak_q;
        `HRSP_OFS_HUMID_PEAK: rd_mux = humid_peak_q;
        `HRSP_OFS_EVENT_ENABLE: rd_mux = {enable_q, 3'h0};
        default: rd_mux = 8'h00;
      endcase
    end
  endfunction

  // Resolution mask applied to a fresh humidity conversion.
  function [13:0] res_mask;
    input [1:0] sel;
    begin
      case (sel)
        `HRSP_RES_11BIT: res_mask = `HRSP_MASK_11BIT;
        `HRSP_RES_9BIT: res_mask = `HRSP_MASK_9BIT;
        default: res_mask = `HRSP_MASK_14BIT;
      endcase
    end
  endfunction

  // Byte under the pointer, and the reset images cut to the stored fields.
  wire [7:0] rd_byte = rd_mux(ptr_q);
  wire [7:0] rst_status = `HRSP_RST_EVENT_STATUS;
  wire [7:0] rst_enable = `HRSP_RST_EVENT_ENABLE;

  // Serial bus slave: address, pointer, write data and auto-incrementing reads.
  always @(posedge clk_sys) begin
    if (srst) begin
      state_q <= ST_IDLE;
      shift_q <= 8'h00;
      bit_cnt_q <= 4'h0;
      byte_done_q <= 1'b0;
      rw_q <= 1'b0;
      ptr_valid_q <= 1'b0;
      ptr_q <= 8'h00;
      tx_q <= 8'h00;
      nack_q <= 1'b0;
      sda_o <= 1'b0;
      sda_oe <= 1'b0;
      rd_evt_q <= 1'b0;
      rd_addr_q <= 8'h00;
      wr_evt_q <= 1'b0;
      wr_addr_q <= 8'h00;
      wr_data_q <= 8'h00;
    end else begin
      rd_evt_q <= 1'b0;
      wr_evt_q <= 1'b0;
      sda_o <= 1'b0;
      if (bus_stop) begin
        state_q <= ST_IDLE;
        sda_oe <= 1'b0;
      end else if (bus_start) begin
        state_q <= ST_ADDR;
        bit_cnt_q <= 4'h0;
        byte_done_q <= 1'b0;
        ptr_valid_q <= 1'b0;
        sda_oe <= 1'b0;
      end else begin
        case (state_q)
          ST_ADDR, ST_PTR, ST_WDATA: begin
            if (scl_rise && !byte_done_q) begin
              shift_q <= {shift_q[6:0], sda_in};
              bit_cnt_q <= bit_cnt_q + 4'h1;
              byte_done_q <= (bit_cnt_q == 4'h7);
            end else if (scl_fall && byte_done_q) begin
              byte_done_q <= 1'b0;
              bit_cnt_q <= 4'h0;
              if (state_q == ST_ADDR) begin
                if (shift_q[7:1] == DEV_ADDR) begin
                  rw_q <= shift_q[0];
                  sda_oe <= 1'b1;
                  state_q <= ST_ACK;
                end else begin
                  state_q <= ST_IDLE;
                end
              end else if (state_q == ST_PTR) begin
                ptr_q <= shift_q;
                ptr_valid_q <= 1'b1;
                sda_oe <= 1'b1;
                state_q <= ST_ACK;
              end else begin
                wr_evt_q <= 1'b1;
                wr_addr_q <= ptr_q;
                wr_data_q <= shift_q;
                ptr_q <= ptr_q + 8'h01;
                sda_oe <= 1'b1;
                state_q <= ST_ACK;
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              if (rw_q) begin
                // Snapshot taken here; the clear it causes follows one cycle later.
                tx_q <= {rd_byte[6:0], 1'b0};
                sda_oe <= !rd_byte[7];
                rd_evt_q <= 1'b1;
                rd_addr_q <= ptr_q;
                ptr_q <= ptr_q + 8'h01;
                bit_cnt_q <= 4'h1;
                state_q <= ST_TX;
              end else begin
                sda_oe <= 1'b0;
                state_q <= ptr_valid_q ? ST_WDATA : ST_PTR;
              end
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              if (bit_cnt_q == 4'h8) begin
                sda_oe <= 1'b0;
                state_q <= ST_RACK;
              end else begin
                sda_oe <= !tx_q[7];
                tx_q <= {tx_q[6:0], 1'b0};
                bit_cnt_q <= bit_cnt_q + 4'h1;
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              nack_q <= sda_in;
            end else if (scl_fall) begin
              if (nack_q) begin
                state_q <= ST_IDLE;
              end else begin
                tx_q <= {rd_byte[6:0], 1'b0};
                sda_oe <= !rd_byte[7];
                rd_evt_q <= 1'b1;
                rd_addr_q <= ptr_q;
                ptr_q <= ptr_q + 8'h01;
                bit_cnt_q <= 4'h1;
                state_q <= ST_TX;
              end
            end
          end
          default: begin
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // Conversion results; the humidity word carries the 14-bit value above two zero bits.
  always @(posedge clk_sys) begin
    if (srst || soft_reset) begin
      temp_word_q <= `HRSP_RST_TEMP_RESULT;
      humid_word_q <= `HRSP_RST_HUMID_RESULT;
    end else begin
      if (temp_done) begin
        temp_word_q <= {temp_word[15:2], 2'h0};
      end
      if (humid_done) begin
        humid_word_q <= {humid_value & res_mask(humid_res_sel), 2'h0};
      end
    end
  end

  // Status flags: a set arriving together with a clearing read wins.
  wire stat_read = rd_evt_q && (rd_addr_q == `HRSP_OFS_EVENT_STATUS);
  wire result_read = rd_evt_q && (rd_addr_q <= `HRSP_OFS_HUMID_HIGH);
  wire [NF-1:0] flag_set;
  wire [NF-1:0] flag_clr;
  wire [NF-1:0] flag_level;

  assign flag_set = {temp_done || humid_done, temp_over_high_cond,
                     temp_under_low_cond, humid_over_high_cond, humid_under_low_cond};
  assign flag_clr = {stat_read || result_read, {(NF-1){stat_read}}};
  // In level mode the threshold flags drop with their condition.
  assign flag_level = {1'b0, {(NF-1){alert_level_mode}}};

  genvar f;
  generate
    for (f = 0; f < NF; f = f + 1) begin : g_flag
      always @(posedge clk_sys) begin
        if (srst || soft_reset) begin
          flag_q[f] <= rst_status[f + `HRSP_FLAG_LSB];
        end else if (flag_level[f]) begin
          flag_q[f] <= flag_set[f];
        end else begin
          flag_q[f] <= flag_set[f] || (flag_q[f] && !flag_clr[f]);
        end
      end
    end
  endgenerate

  // Peak detectors follow host-requested conversions only.
  wire peak_track = !auto_mode;
  wire temp_wr = wr_evt_q && (wr_addr_q == `HRSP_OFS_TEMP_PEAK);
  wire humid_wr = wr_evt_q && (wr_addr_q == `HRSP_OFS_HUMID_PEAK);
  wire [15:0] humid_new = {humid_value & res_mask(humid_res_sel), 2'h0};

  always @(posedge clk_sys) begin
    if (srst || soft_reset) begin
      temp_peak_q <= `HRSP_RST_PEAK;
      humid_peak_q <= `HRSP_RST_PEAK;
    end else begin
      if (temp_wr) begin
        temp_peak_q <= wr_data_q;
      end else if (temp_done && peak_track && (temp_word[15:8] > temp_peak_q)) begin
        temp_peak_q <= temp_word[15:8];
      end
      if (humid_wr) begin
        humid_peak_q <= wr_data_q;
      end else if (humid_done && peak_track && (humid_new[15:8] > humid_peak_q)) begin
        humid_peak_q <= humid_new[15:8];
      end
    end
  end

  // Event enable register; reserved bits are not stored.
  always @(posedge clk_sys) begin
    if (srst || soft_reset) begin
      enable_q <= rst_enable[7:`HRSP_FLAG_LSB];
    end else if (wr_evt_q && (wr_addr_q == `HRSP_OFS_EVENT_ENABLE)) begin
      enable_q <= wr_data_q[7:`HRSP_FLAG_LSB];
    end
  end

  // Alert pin: any enabled flag asserts it, in the selected polarity.
  wire alert_active = alert_enable && |(flag_q & enable_q);

  always @(posedge clk_sys) begin
    if (srst) begin
      alert_pin <= 1'b0;
    end else begin
      alert_pin <= alert_active_high ? alert_active : !alert_active;
    end
  end

endmodule // hrsp_regs

`default_nettype wire

//--- verification/hrsp_regs_checker.sv
// Pin-level assertion checker for the humidity result, status and peak register block.
`timescale 1ns/1ps
`default_nettype none
module hrsp_regs_checker (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic srst,
  // Bus pins, alert pin and its settings.
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic alert_enable,
  input wire logic alert_active_high,
  input wire logic alert_pin
);
  logic [7:0] drive_cnt_q;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  // A stuck data driver would hang the bus, so the pull time is counted.
  always @(posedge clk_sys) begin
    if (srst || !sda_oe) drive_cnt_q <= 8'h00;
    else if (drive_cnt_q != 8'hFF) drive_cnt_q <= drive_cnt_q + 8'h01;
  end
  rst_quiet_a: assert property ($fell(srst) |-> !sda_oe && !alert_pin)
    else $error("pins not idle through reset");
  alert_release_a: assert property ($fell(srst) |=> alert_pin == !alert_active_high)
    else $error("alert pin active after reset");
  open_drain_a: assert property (sda_oe |-> !sda_o)
    else $error("data pin driven high");
  drive_on_low_a: assert property ($changed(sda_oe) |-> !$past(scl_i, 2))
    else $error("data pin changed while clock high");
  drive_stands_a: assert property ($rose(sda_oe) |=> sda_oe [*4])
    else $error("data pin pull too short");
  drive_bound_a: assert property (drive_cnt_q < 8'h96)
    else $error("data pin pulled too long");
  alert_idle_a: assert property ((!alert_enable && $stable(alert_active_high)) [*3]
    |-> alert_pin == !alert_active_high)
    else $error("alert pin active while disabled");
  stop_quiet_a: assert property (scl_i && $past(scl_i) && $rose(sda_i) |=> !sda_oe [*8])
    else $error("data pin pulled after stop");
endmodule // hrsp_regs_checker
bind hrsp_regs hrsp_regs_checker chk_u (.clk_sys(clk_sys), .srst(srst), .scl_i(scl_i),
  .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .alert_enable(alert_enable),
  .alert_active_high(alert_active_high), .alert_pin(alert_pin));
`default_nettype wire

//--- verification/hrsp_host.sv
// Bus controller model standing in for the host on the serial register bus.
`timescale 1ns/1ps
`default_nettype none
`include "hrsp_defines.vh"
module hrsp_host (
  // Bus clock and data pull; data floats high unless pulled.
  output logic scl,
  output logic sda_pull,
  input wire logic sda
);
  localparam real QTR = 31.25;
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // Data moves halfway into the low phase and is sampled mid-high.
  task automatic bit_io(input logic b, output logic r);
    sda_pull = !b;
    #QTR scl = 1'b1;
    #QTR r = sda;
    #QTR scl = 1'b0;
    #QTR;
  endtask
  task automatic start();
    sda_pull = 1'b0;
    #QTR scl = 1'b1;
    #QTR sda_pull = 1'b1;
    #QTR scl = 1'b0;
    #QTR;
  endtask
  // The clock is left standing high between frames.
  task automatic stop();
    sda_pull = 1'b1;
    #QTR scl = 1'b1;
    #QTR sda_pull = 1'b0;
    #QTR;
  endtask
  task automatic xbyte(input logic [7:0] d, input logic a, output logic [7:0] q, output logic n);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(a, n);
  endtask
  task automatic write_reg(input logic [7:0] p, input logic [7:0] d, output logic nak);
    logic [7:0] q;
    logic n0, n1, n2;
    start();
    xbyte({`HRSP_DEV_ADDR, 1'b0}, 1'b1, q, n0);
    xbyte(p, 1'b1, q, n1);
    xbyte(d, 1'b1, q, n2);
    stop();
    nak = n0 | n1 | n2;
  endtask
  task automatic read_reg(input logic [7:0] p, output logic [7:0] d, output logic nak);
    logic [7:0] q;
    logic n0, n1, n2, n3;
    start();
    xbyte({`HRSP_DEV_ADDR, 1'b0}, 1'b1, q, n0);
    xbyte(p, 1'b1, q, n1);
    start();
    xbyte({`HRSP_DEV_ADDR, 1'b1}, 1'b1, q, n2);
    xbyte(8'hFF, 1'b1, d, n3);
    stop();
    nak = n0 | n1 | n2;
  endtask
endmodule // hrsp_host
`default_nettype wire

//--- verification/hrsp_regs_tb_top.sv
// Self-checking bench for the humidity result, status and peak register block.
`timescale 1ns/1ps
`default_nettype none
module hrsp_regs_tb_top;
  logic clk_sys, srst, scl, host_pull, temp_done, humid_done, auto_mode;
  logic alert_enable, alert_active_high, soft_reset, level_mode;
  logic [15:0] temp_word;
  logic [13:0] humid_value;
  logic [1:0] humid_res_sel;
  logic [3:0] cond;
  logic [7:0] lows [4] = '{8'hFC, 8'hE0, 8'h80, 8'hFC};
  wire sda_oe, sda_o, alert_pin;
  wire sda = !(sda_oe || host_pull);
  int mismatches, comparisons;
  hrsp_regs dut_u (.clk_sys(clk_sys), .srst(srst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .temp_done(temp_done), .temp_word(temp_word), .humid_done(humid_done),
    .humid_value(humid_value), .humid_res_sel(humid_res_sel), .auto_mode(auto_mode),
    .temp_over_high_cond(cond[3]), .temp_under_low_cond(cond[2]),
    .humid_over_high_cond(cond[1]), .humid_under_low_cond(cond[0]),
    .alert_enable(alert_enable), .alert_active_high(alert_active_high),
    .alert_level_mode(level_mode), .soft_reset(soft_reset), .alert_pin(alert_pin));
  hrsp_host host_u (.scl(scl), .sda_pull(host_pull), .sda(sda));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = !clk_sys;
  end
  task automatic end_sim();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t ns: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic reg_is(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic n;
    host_u.read_reg(a, d, n);
    check({7'h00, n}, 8'h00);
    check(d, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic n;
    host_u.write_reg(a, d, n);
    check({7'h00, n}, 8'h00);
  endtask
  task automatic pulse(input int i);
    @(negedge clk_sys) cond[i] = 1'b1;
    repeat (3) @(negedge clk_sys);
    cond[i] = 1'b0;
  endtask
  task automatic conv(input logic t, input logic [15:0] w, input logic [1:0] r);
    @(negedge clk_sys);
    temp_word = w;
    humid_value = w[13:0];
    humid_res_sel = r;
    temp_done = t;
    humid_done = !t;
    @(negedge clk_sys);
    temp_done = 1'b0;
    humid_done = 1'b0;
    repeat (2) @(negedge clk_sys);
  endtask
  initial begin
    #800000;
    mismatches++;
    end_sim();
  end
  initial begin
    {srst, alert_active_high} = 2'h3;
    {temp_done, humid_done, auto_mode, alert_enable, soft_reset, level_mode} = 6'h00;
    {temp_word, humid_value, humid_res_sel, cond} = 36'h0;
    repeat (6) @(negedge clk_sys);
    srst = 1'b0;
    repeat (8) @(negedge clk_sys);
    reg_is(8'h03, 8'h00);
    reg_is(8'h04, 8'h00);
    reg_is(8'h05, 8'h00);
    reg_is(8'h06, 8'h00);
    reg_is(8'h07, 8'h00);
    reg_is(8'h3C, 8'h00);
    conv(1'b0, 16'h2000, 2'h0);
    reg_is(8'h04, 8'h80);
    reg_is(8'h04, 8'h00);
    reg_is(8'h06, 8'h80);
    conv(1'b0, 16'h1000, 2'h0);
    reg_is(8'h06, 8'h80);
    for (int r = 0; r < 4; r++) begin
      conv(1'b0, 16'h3FFF, r[1:0]);
      reg_is(8'h02, lows[r]);
      reg_is(8'h03, 8'hFF);
      reg_is(8'h04, 8'h00);
    end
    conv(1'b1, 16'h5003, 2'h0);
    reg_is(8'h00, 8'h00);
    reg_is(8'h01, 8'h50);
    reg_is(8'h04, 8'h00);
    reg_is(8'h05, 8'h50);
    conv(1'b1, 16'h4F00, 2'h0);
    reg_is(8'h05, 8'h50);
    @(negedge clk_sys) auto_mode = 1'b1;
    conv(1'b1, 16'h7000, 2'h0);
    reg_is(8'h05, 8'h50);
    @(negedge clk_sys) auto_mode = 1'b0;
    conv(1'b1, 16'h6100, 2'h0);
    reg_is(8'h05, 8'h61);
    wr(8'h03, 8'h55);
    reg_is(8'h03, 8'hFF);
    wr(8'h04, 8'hF8);
    reg_is(8'h04, 8'h00);
    wr(8'h06, 8'h33);
    reg_is(8'h06, 8'h33);
    @(negedge clk_sys) soft_reset = 1'b1;
    @(negedge clk_sys) soft_reset = 1'b0;
    reg_is(8'h05, 8'h00);
    reg_is(8'h06, 8'h00);
    for (int i = 0; i < 4; i++) begin
      pulse(i);
      reg_is(8'h04, 8'h08 << i);
      reg_is(8'h04, 8'h00);
    end
    @(negedge clk_sys) cond[3] = 1'b1;
    reg_is(8'h04, 8'h40);
    reg_is(8'h04, 8'h40);
    @(negedge clk_sys) cond[3] = 1'b0;
    reg_is(8'h04, 8'h40);
    reg_is(8'h04, 8'h00);
    @(negedge clk_sys) level_mode = 1'b1;
    cond[1] = 1'b1;
    reg_is(8'h04, 8'h10);
    @(negedge clk_sys) cond[1] = 1'b0;
    repeat (2) @(negedge clk_sys);
    reg_is(8'h04, 8'h00);
    level_mode = 1'b0;
    wr(8'h07, 8'hF8);
    reg_is(8'h07, 8'hF8);
    wr(8'h07, 8'h40);
    @(negedge clk_sys) alert_enable = 1'b1;
    conv(1'b1, 16'h1000, 2'h0);
    check({7'h00, alert_pin}, 8'h00);
    pulse(3);
    check({7'h00, alert_pin}, 8'h01);
    reg_is(8'h04, 8'hC0);
    repeat (3) @(negedge clk_sys);
    check({7'h00, alert_pin}, 8'h00);
    alert_active_high = 1'b0;
    repeat (3) @(negedge clk_sys);
    check({7'h00, alert_pin}, 8'h01);
    end_sim();
  end
endmodule // hrsp_regs_tb_top
`default_nettype wire
